// >>> hw/ccd_top.sv
// Purpose: Clock channel divider and two output driver settings, AHB-Lite slave
// Assumes: Prescaler clocks and lock flags arrive from outside clk_i domain
// Notes: Zero wait state bus; prescaler clocks must be well below clk_i / 4
`include "ccd_consts.svh"

module ccd_top #(
  parameter int RW = 10,
  parameter int PW = 6,
  parameter int ND = 2
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [15:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic first_prescaler_i,
  input wire logic second_prescaler_i,
  input wire logic freq_lock_i,
  input wire logic phase_lock_i,
  output logic channel_clk_o,
  output logic channel_pd_o,
  output logic [ND-1:0] drv_en_o,
  output logic [ND-1:0] drv_p_o,
  output logic [ND-1:0] drv_n_o,
  output logic [ND*3-1:0] drv_fmt_o,
  output logic [ND*2-1:0] drv_pol_o,
  output logic [ND-1:0] drv_boost_o
);
  import ccd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [RW-1:0] ratio_r;
  logic pd_r;
  logic pre_sel_r;
  logic [PW-1:0] phase_r;
  ccd_fmt_t fmt_r [ND];
  logic [1:0] pol_r [ND];
  logic [ND-1:0] boost_r;
  logic [ND-1:0] en_r;
  ccd_autosync_t autosync_r;
  logic man_sync_r;
  ccd_bus_t bus_r;
  ccd_bus_t bus_nxt;
  logic [11:0] idx_r;
  logic [11:0] idx_a;
  logic addr_ok;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic freq_q_r;
  logic phase_q_r;
  logic auto_sync;
  logic sync_evt;
  logic src_sel;
  logic div_clk;
  logic [31:0] rd_nxt;
  logic [3:0] pins;

  // Word index of the address phase; low two bits ignored
  assign idx_a = haddr_i[13:2];
  assign addr_ok = haddr_i[15:14] == 2'b00;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pins = {phase_lock_i, freq_lock_i, second_prescaler_i, first_prescaler_i};

  // Two flops per pin; first stage feeds only the second
  genvar gs;
  generate
    for (gs = 0; gs < 4; gs++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sync1_r[gs] <= 1'b0;
          sync2_r[gs] <= 1'b0;
        end else begin
          sync1_r[gs] <= pins[gs];
          sync2_r[gs] <= sync1_r[gs];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------
  always_comb begin
    bus_nxt = CCD_BUS_IDLE;
    if (hsel_i && hready_i && htrans_i[1]) begin
      bus_nxt = hwrite_i ? CCD_BUS_WRITE : CCD_BUS_READ;
    end
  end

  // Latch address phase for the data phase
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_r <= CCD_BUS_IDLE;
      idx_r <= 12'h000;
    end else begin
      bus_r <= bus_nxt;
      idx_r <= addr_ok ? idx_a : 12'hfff;
    end
  end

  // Never stalls and never errors
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ratio_r <= `CCD_RST_RATIO;
      pd_r <= 1'b0;
      pre_sel_r <= 1'b0;
      phase_r <= `CCD_RST_PHASE;
      autosync_r <= CCD_AS_PHASE;
    end else if (bus_r == CCD_BUS_WRITE) begin
      case (idx_r)
        `CCD_IDX_RATIO_LO: ratio_r[7:0] <= hwdata_i[7:0];
        `CCD_IDX_CTRL_HI: begin
          ratio_r[RW-1:8] <= hwdata_i[1:0];
          pd_r <= hwdata_i[`CCD_BIT_PD];
          pre_sel_r <= hwdata_i[`CCD_BIT_PRE_SEL];
        end
        `CCD_IDX_PHASE: phase_r <= hwdata_i[PW-1:0];
        `CCD_IDX_SYNC_CFG: autosync_r <= ccd_autosync_t'(hwdata_i[1:0]);
        default: ;
      endcase
    end
  end

  // Manual sync is a self-clearing command bit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      man_sync_r <= 1'b0;
    end else begin
      man_sync_r <= (bus_r == CCD_BUS_WRITE) && (idx_r == `CCD_IDX_SYNC_CFG)
                    && hwdata_i[`CCD_BIT_SYNC_CMD];
    end
  end

  // ----------------------------------------------------------------
  // Driver registers, one per driver
  // ----------------------------------------------------------------
  genvar gd;
  generate
    for (gd = 0; gd < ND; gd++) begin : g_drv
      localparam logic [11:0] IDX = `CCD_IDX_DRV1 + 12'(gd);
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          fmt_r[gd] <= CCD_FMT_HSTL;
          pol_r[gd] <= `CCD_RST_POL;
          boost_r[gd] <= 1'b0;
          en_r[gd] <= 1'b0;
        end else if (bus_r == CCD_BUS_WRITE && idx_r == IDX) begin
          fmt_r[gd] <= ccd_fmt_t'(hwdata_i[6:4]);
          pol_r[gd] <= hwdata_i[3:2];
          boost_r[gd] <= hwdata_i[`CCD_BIT_BOOST];
          en_r[gd] <= hwdata_i[`CCD_BIT_DRV_EN];
        end
      end

      // Pad drive from the divided clock
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          drv_en_o[gd] <= 1'b0;
          drv_p_o[gd] <= 1'b0;
          drv_n_o[gd] <= 1'b0;
          drv_fmt_o[gd*3 +: 3] <= `CCD_RST_FMT;
          drv_pol_o[gd*2 +: 2] <= `CCD_RST_POL;
          drv_boost_o[gd] <= 1'b0;
        end else begin
          drv_fmt_o[gd*3 +: 3] <= fmt_r[gd];
          // Reserved codes and off code keep the pad quiet
          drv_en_o[gd] <= en_r[gd] && !pd_r && fmt_r[gd] != CCD_FMT_OFF
                          && fmt_r[gd] != CCD_FMT_RSV3 && fmt_r[gd] != CCD_FMT_RSV7;
          case (fmt_r[gd])
            CCD_FMT_CMOS_PN, CCD_FMT_CMOS_P, CCD_FMT_CMOS_N: begin
              drv_pol_o[gd*2 +: 2] <= pol_r[gd];
              drv_boost_o[gd] <= 1'b0;
              drv_p_o[gd] <= (fmt_r[gd] != CCD_FMT_CMOS_N) && (div_clk ^ pol_r[gd][1]);
              // N leg is inverted only for the matched codes, positive for the mixed ones
              drv_n_o[gd] <= (fmt_r[gd] != CCD_FMT_CMOS_P)
                             && (div_clk ^ !(pol_r[gd][1] ^ pol_r[gd][0]));
            end
            CCD_FMT_LVDS: begin
              drv_pol_o[gd*2 +: 2] <= `CCD_RST_POL;
              drv_boost_o[gd] <= boost_r[gd];
              drv_p_o[gd] <= div_clk;
              drv_n_o[gd] <= !div_clk;
            end
            CCD_FMT_HSTL: begin
              drv_pol_o[gd*2 +: 2] <= `CCD_RST_POL;
              drv_boost_o[gd] <= 1'b0;
              drv_p_o[gd] <= div_clk;
              drv_n_o[gd] <= !div_clk;
            end
            default: begin
              drv_pol_o[gd*2 +: 2] <= `CCD_RST_POL;
              drv_boost_o[gd] <= 1'b0;
              drv_p_o[gd] <= 1'b0;
              drv_n_o[gd] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sync event selection
  // ----------------------------------------------------------------
  // Lock edges, taken from the synchronised copies only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      freq_q_r <= 1'b0;
      phase_q_r <= 1'b0;
    end else begin
      freq_q_r <= sync2_r[2];
      phase_q_r <= sync2_r[3];
    end
  end

  // Reserved mode gives no automatic sync
  always_comb begin
    case (autosync_r)
      CCD_AS_FREQ: auto_sync = sync2_r[2] && !freq_q_r;
      CCD_AS_PHASE: auto_sync = sync2_r[3] && !phase_q_r;
      default: auto_sync = 1'b0;
    endcase
  end

  assign sync_evt = man_sync_r || auto_sync;
  assign src_sel = pre_sel_r ? sync2_r[1] : sync2_r[0];

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  ccd_divider #(
    .RW(RW),
    .PW(PW)
  ) u_div (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .src_i(src_sel),
    .pd_i(pd_r),
    .ratio_i(ratio_r),
    .phase_i(phase_r),
    .sync_i(sync_evt),
    .div_o(div_clk)
  );

  // Channel outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      channel_clk_o <= 1'b0;
      channel_pd_o <= 1'b0;
    end else begin
      channel_clk_o <= div_clk;
      channel_pd_o <= pd_r;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Reserved bits assemble as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (idx_a)
      `CCD_IDX_RATIO_LO: rd_nxt[7:0] = ratio_r[7:0];
      `CCD_IDX_CTRL_HI: rd_nxt[3:0] = {pd_r, pre_sel_r, ratio_r[RW-1:8]};
      `CCD_IDX_PHASE: rd_nxt[PW-1:0] = phase_r;
      `CCD_IDX_DRV1: rd_nxt[6:0] = {fmt_r[0], pol_r[0], boost_r[0], en_r[0]};
      `CCD_IDX_DRV2: rd_nxt[6:0] = {fmt_r[1], pol_r[1], boost_r[1], en_r[1]};
      `CCD_IDX_SYNC_CFG: rd_nxt[1:0] = autosync_r;
      `CCD_IDX_STATUS: rd_nxt[3:0] = {sync2_r[3], sync2_r[2], div_clk, !pd_r};
      default: ;
    endcase
    if (!addr_ok) begin
      rd_nxt = 32'h0000_0000;
    end
  end

  // Read word ready in the data phase
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (bus_nxt == CCD_BUS_READ) begin
      hrdata_o <= rd_nxt;
    end
  end
endmodule // ccd_top

// >>> hw/ccd_consts.svh
// Purpose: Offsets, field positions, reset values for the clock channel block
// Assumes: Register index times four gives the AHB byte address
// Notes: Definitions only
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define CCD_IDX_RATIO_LO 12'h502
`define CCD_IDX_CTRL_HI 12'h503
`define CCD_IDX_PHASE 12'h504
`define CCD_IDX_DRV1 12'h505
`define CCD_IDX_DRV2 12'h506
`define CCD_IDX_SYNC_CFG 12'h520
`define CCD_IDX_STATUS 12'h521

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCD_BIT_PD 3
`define CCD_BIT_PRE_SEL 2
`define CCD_BIT_BOOST 1
`define CCD_BIT_DRV_EN 0
`define CCD_BIT_SYNC_CMD 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCD_RST_RATIO 10'h000
`define CCD_RST_PHASE 6'h00
`define CCD_RST_FMT 3'h1
`define CCD_RST_POL 2'h0
`define CCD_RST_AUTOSYNC 2'h2

// ----------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------
`define CCD_HTRANS_NONSEQ 2'h2
`define CCD_HTRANS_SEQ 2'h3
`endif

// >>> hw/ccd_pkg.sv
// Purpose: Types shared by the clock channel block
// Assumes: Constants live in ccd_consts.svh
// Notes: One-hot bus phase codes
package ccd_pkg;
  // Driver format codes
  typedef enum logic [2:0] {
    CCD_FMT_OFF = 3'h0,
    CCD_FMT_HSTL = 3'h1,
    CCD_FMT_LVDS = 3'h2,
    CCD_FMT_RSV3 = 3'h3,
    CCD_FMT_CMOS_PN = 3'h4,
    CCD_FMT_CMOS_P = 3'h5,
    CCD_FMT_CMOS_N = 3'h6,
    CCD_FMT_RSV7 = 3'h7
  } ccd_fmt_t;

  // Automatic sync source
  typedef enum logic [1:0] {
    CCD_AS_MANUAL = 2'h0,
    CCD_AS_FREQ = 2'h1,
    CCD_AS_PHASE = 2'h2,
    CCD_AS_RSV = 2'h3
  } ccd_autosync_t;

  // Bus data-phase state
  typedef enum logic [2:0] {
    CCD_BUS_IDLE = 3'b001,
    CCD_BUS_WRITE = 3'b010,
    CCD_BUS_READ = 3'b100
  } ccd_bus_t;
endpackage

// >>> hw/ccd_divider.sv
// Purpose: Channel divider counting half periods of the prescaler clock
// Assumes: src_i already synchronised to clk_i
// Notes: Output is 50 percent duty, period 2*(ratio+1) half periods
module ccd_divider #(
  parameter int RW = 10,
  parameter int PW = 6
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic src_i,
  input wire logic pd_i,
  input wire logic [RW-1:0] ratio_i,
  input wire logic [PW-1:0] phase_i,
  input wire logic sync_i,
  output logic div_o
);
  logic src_q_r;
  logic [RW:0] hcnt_r;
  logic [RW:0] hcnt_nxt;
  logic [RW:0] last;
  logic edge_seen;

  // Every input edge is one half period
  assign edge_seen = src_i ^ src_q_r;
  assign last = {ratio_i, 1'b1};

  // ----------------------------------------------------------------
  // Half period counter
  // ----------------------------------------------------------------
  always_comb begin
    hcnt_nxt = hcnt_r;
    if (pd_i) begin
      hcnt_nxt = '0;
    end else if (sync_i) begin
      hcnt_nxt = {{(RW+1-PW){1'b0}}, phase_i};
    end else if (edge_seen) begin
      hcnt_nxt = (hcnt_r >= last) ? '0 : hcnt_r + 1'b1;
    end
  end

  // Edge history, counter and output
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_q_r <= 1'b0;
      hcnt_r <= '0;
      div_o <= 1'b0;
    end else begin
      src_q_r <= src_i;
      hcnt_r <= hcnt_nxt;
      div_o <= !pd_i && (hcnt_nxt <= {1'b0, ratio_i});
    end
  end
endmodule // ccd_divider

// >>> verif/ccd_checker.sv
// Purpose: Port checks for the clock channel block
// Assumes: Zero wait bus, driver outputs registered together
// Notes: Bound into ccd_top after the module
module ccd_checker #(
  parameter int RW = 10,
  parameter int PW = 6,
  parameter int ND = 2
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic channel_clk_o,
  input wire logic channel_pd_o,
  input wire logic [ND-1:0] drv_en_o,
  input wire logic [ND-1:0] drv_p_o,
  input wire logic [ND-1:0] drv_n_o,
  input wire logic [ND*3-1:0] drv_fmt_o,
  input wire logic [ND*2-1:0] drv_pol_o,
  input wire logic [ND-1:0] drv_boost_o
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic rd_take;
  // Read address phase accepted
  assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  a_resp_okay: assert property (hreadyout_o && !hresp_o) else $error("bus answer not ready or okay");
  a_rdata_hold: assert property (!rd_take |=> $stable(hrdata_o)) else $error("read data moved");
  a_pd_clk_low: assert property (channel_pd_o [*3] |-> !channel_clk_o) else $error("clock runs powered down");
  a_pd_drv_off: assert property (channel_pd_o [*2] |-> drv_en_o == '0) else $error("driver on powered down");
  a_fmt_off_one: assert property ((drv_fmt_o[2:0] inside {3'h0, 3'h3, 3'h7}) [*2] |-> !drv_en_o[0])
    else $error("first driver on in off format");
  a_fmt_off_two: assert property ((drv_fmt_o[5:3] inside {3'h0, 3'h3, 3'h7}) [*2] |-> !drv_en_o[1])
    else $error("second driver on in off format");
  a_pol_cmos_only: assert property (!(drv_fmt_o[2:0] inside {3'h4, 3'h5, 3'h6}) |-> drv_pol_o[1:0] == 2'h0)
    else $error("polarity outside cmos");
  a_boost_lvds_one: assert property (drv_boost_o[0] |-> drv_fmt_o[2:0] == 3'h2) else $error("boost outside lvds");
  a_boost_lvds_two: assert property (drv_boost_o[1] |-> drv_fmt_o[5:3] == 3'h2) else $error("boost outside lvds");
  a_cmos_p_leg: assert property ((drv_fmt_o[2:0] == 3'h5) [*2] |-> !drv_n_o[0]) else $error("idle leg driven");
  a_cmos_p_pol: assert property (drv_fmt_o[2:0] == 3'h4 |->
    drv_p_o[0] == (channel_clk_o ^ drv_pol_o[1])) else $error("first driver P leg polarity wrong");
  a_cmos_n_pol: assert property (drv_fmt_o[2:0] == 3'h4 |->
    drv_n_o[0] == (channel_clk_o ^ !(drv_pol_o[1] ^ drv_pol_o[0]))) else $error("first driver N leg polarity wrong");
  // Main scenarios reached
  c_read: cover property (rd_take);
  c_pd: cover property (channel_pd_o);
  c_cmos: cover property (drv_en_o[0] && drv_fmt_o[2:0] == 3'h4);
endmodule // ccd_checker

bind ccd_top ccd_checker #(.RW(RW), .PW(PW), .ND(ND)) ccd_checker_inst (.*);

// >>> verif/ccd_top_tb.sv
// Purpose: Self-checking bench for the clock channel block
// Assumes: Zero wait bus; prescalers of 16 and 24 clock periods
// Notes: Inputs change by non-blocking assignment at the rising edge
module ccd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [15:0] haddr_i = '0;
  logic [1:0] htrans_i = '0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = '0;
  logic first_prescaler_i = 1'b0;
  logic second_prescaler_i = 1'b0;
  logic freq_lock_i = 1'b0;
  logic phase_lock_i = 1'b0;
  wire logic hready_i;
  logic hreadyout_o, hresp_o, channel_clk_o, channel_pd_o;
  logic [31:0] hrdata_o;
  logic [1:0] drv_en_o, drv_p_o, drv_n_o, drv_boost_o;
  logic [5:0] drv_fmt_o;
  logic [3:0] drv_pol_o;
  logic [31:0] rst_v [5] = '{32'h0, 32'h0, 32'h0, 32'h10, 32'h10};
  logic [31:0] msk_v [5] = '{32'hff, 32'hf, 32'h3f, 32'h7f, 32'h7f};
  int fails = 0;
  int cmp_count = 0;
  int pcnt = 0;

  ccd_top ccd_top_inst (.*);
  // Single slave: its ready is the bus ready
  assign hready_i = hreadyout_o;

  // ----------------------------------------------------------------
  // Clock, prescalers, watchdog
  // ----------------------------------------------------------------
  always #2.5 clk_i = ~clk_i;
  // Slow prescalers, well below a quarter of clk_i
  always @(posedge clk_i) begin
    pcnt <= pcnt + 1;
    if (pcnt % 8 == 7) first_prescaler_i <= ~first_prescaler_i;
    if (pcnt % 12 == 11) second_prescaler_i <= ~second_prescaler_i;
  end
  // Runs hold about 13k cycles; cut a hang well beyond
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One AHB single transfer, held until ready is sampled
  task automatic bus(logic [11:0] idx, logic is_wr, logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {2'b00, idx, 2'b00};
    hwrite_i <= is_wr;
    htrans_i <= 2'h2;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic wr(logic [11:0] idx, logic [31:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, d, x);
  endtask
  task automatic rd_chk(string n, logic [11:0] idx, logic [31:0] exp);
    logic [31:0] x;
    bus(idx, 1'b0, 32'h0, x);
    check(n, exp, x);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      rd_chk("reset value", 12'h502 + 12'(i), rst_v[i]);
      wr(12'h502 + 12'(i), 32'hffff_ffff);
      rd_chk("writable bits", 12'h502 + 12'(i), msk_v[i]);
    end
    rd_chk("unmapped", 12'h510, 32'h0);
    repeat (2) @(posedge clk_i);
    check("channel_pd", 32'h1, 32'(channel_pd_o));
    check("drv_en reserved fmt", 32'h0, 32'(drv_en_o));
    check("drv_fmt", 32'h3f, 32'(drv_fmt_o));
    $display("test regs done");
  endtask
  task automatic t_div(logic [9:0] r, logic sel);
    realtime t0;
    wr(12'h502, {24'h0, r[7:0]});
    wr(12'h503, {28'h0, 1'b0, sel, r[9:8]});
    repeat (2) @(posedge channel_clk_o);
    t0 = $realtime;
    @(posedge channel_clk_o);
    check("period", (32'(r) + 1) * (sel ? 24 : 16), 32'(int'(($realtime - t0) / 5.0)));
    $display("test divider %0d done", r);
  endtask
  task automatic t_fmt();
    logic [2:0] f;
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 8; i++) begin
        f = 3'(i);
        wr(12'h505 + 12'(d), {25'h0, f, 4'hf});
        repeat (2) @(posedge clk_i);
        check("drv_fmt", 32'(f), 32'(drv_fmt_o[d*3 +: 3]));
        check("drv_en", 32'(f != 0 && f != 3 && f != 7), 32'(drv_en_o[d]));
        check("drv_pol", (f[2] && f != 7) ? 32'h3 : 32'h0, 32'(drv_pol_o[d*2 +: 2]));
        check("drv_boost", 32'(f == 2), 32'(drv_boost_o[d]));
      end
    end
    $display("test formats done");
  endtask
  // Pads and channel clock launch from the same edge, so they compare directly
  task automatic t_pol();
    logic [1:0] pv;
    for (int d = 0; d < 2; d++) begin
      for (int p = 0; p < 4; p++) begin
        pv = 2'(p);
        wr(12'h505 + 12'(d), {25'h0, 3'h4, pv, 2'h1});
        repeat (3) @(posedge clk_i);
        check("pad pair differs", 32'(pv == 2'h0 || pv == 2'h2), 32'(drv_p_o[d] ^ drv_n_o[d]));
        check("pad P level", 32'(channel_clk_o ^ pv[1]), 32'(drv_p_o[d]));
      end
    end
    $display("test polarity done");
  endtask
  task automatic t_pd();
    int ones;
    ones = 0;
    wr(12'h503, 32'h8);
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_i);
      ones += int'(channel_clk_o !== 1'b0);
    end
    check("clock high while down", 32'h0, 32'(ones));
    check("drv_en while down", 32'h0, 32'(drv_en_o));
    wr(12'h503, 32'h0);
    $display("test power-down done");
  endtask
  // Ratio 3: high for half periods 0..3, so phase 4 starts low
  // Mode 0 has no lock source: the sync comes from the command bit instead
  task automatic t_sync(logic [1:0] mode, logic [5:0] ph, logic exp);
    wr(12'h504, {26'h0, ph});
    wr(12'h520, {29'h0, mode == 2'h0, mode});
    @(posedge clk_i);
    if (mode == 2'h1) freq_lock_i <= 1'b1;
    else if (mode == 2'h2) phase_lock_i <= 1'b1;
    repeat (7) @(posedge clk_i);
    check("level after sync", 32'(exp), 32'(channel_clk_o));
    freq_lock_i <= 1'b0;
    phase_lock_i <= 1'b0;
    $display("test sync mode %0d done", mode);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_div(10'h0, 1'b0);
    t_div(10'h2, 1'b0);
    t_div(10'h2, 1'b1);
    t_div(10'h100, 1'b0);
    t_fmt();
    t_pol();
    t_pd();
    wr(12'h502, 32'h3);
    t_sync(2'h2, 6'h0, 1'b1);
    t_sync(2'h1, 6'h4, 1'b0);
    t_sync(2'h0, 6'h0, 1'b1);
    stop_test();
  end
endmodule // ccd_top_tb
